// File: dv/fpr_backplane.sv
`timescale 1ns/1ps
`default_nettype none

module fpr_backplane (
    input  wire logic drive_en_i,
    input  wire logic drive_lvl_i,
    input  wire logic peer_pull_n_i,
    output wire logic line_n_o
);
    // The pull-up wins once every driver lets go, so no stale level remains.
    assign line_n_o = (drive_en_i ? drive_lvl_i : 1'h1) & peer_pull_n_i;
endmodule // fpr_backplane

`default_nettype wire

// File: dv/fpr_checker.sv
`timescale 1ns/1ps
`default_nettype none

module fpr_checker #(
    parameter integer DEB_CYCLES = 4
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic reset_btn_n_i,
    input wire logic abort_btn_n_i,
    input wire logic por_n_i,
    input wire logic vme_local_reset_n_i,
    input wire logic local_reset_n_o,
    input wire logic dram_reset_n_o,
    input wire logic sysreset_oe_o,
    input wire logic cpu0_nmi_n_o,
    input wire logic vme_sysctl_i,
    input wire logic board_fail_line_i,
    input wire logic cpu_bus_activity_n_i,
    input wire logic lan_bus_master_i,
    input wire logic scsi_bus_master_i,
    input wire logic vme_master_i,
    input wire logic vme_slave_access_i,
    input wire logic fail_led_o,
    input wire logic sysctl_indicator_o,
    input wire logic run_led_o,
    input wire logic lan_led_o,
    input wire logic vme_led_o,
    input wire logic scsi_led_o
);
    // Margin covers the synchroniser stages and the output flop.
    localparam int QUIET = DEB_CYCLES + 6;
    int quiet_q;
    // A margin of four rather than six for a held press while the board is system controller.
    localparam int HOLD = DEB_CYCLES + 4;
    int hold_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            quiet_q <= 0;
        end else if (!(por_n_i && vme_local_reset_n_i && reset_btn_n_i)) begin
            quiet_q <= 0;
        end else if (quiet_q < QUIET) begin
            quiet_q <= quiet_q + 1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold_q <= 0;
        end else if (reset_btn_n_i || !vme_sysctl_i) begin
            hold_q <= 0;
        end else if (hold_q < HOLD) begin
            hold_q <= hold_q + 1;
        end
    end

    a_fail_led: assert property (
        $stable(board_fail_line_i)[*5] |-> fail_led_o == board_fail_line_i)
        else $error("fail lamp wrong");
    a_sysctl_led: assert property (
        $stable(vme_sysctl_i)[*5] |-> sysctl_indicator_o == vme_sysctl_i)
        else $error("controller lamp wrong");
    a_run_led: assert property (
        $stable(cpu_bus_activity_n_i)[*5] |-> run_led_o != cpu_bus_activity_n_i)
        else $error("run lamp wrong");
    a_lan_led: assert property (
        $stable(lan_bus_master_i)[*5] |-> lan_led_o == lan_bus_master_i)
        else $error("network lamp wrong");
    a_vme_led: assert property (
        ($stable(vme_master_i) && $stable(vme_slave_access_i))[*5]
        |-> vme_led_o == (vme_master_i | vme_slave_access_i))
        else $error("bus lamp wrong");
    a_scsi_led: assert property (
        $stable(scsi_bus_master_i)[*5] |-> scsi_led_o == scsi_bus_master_i)
        else $error("disk lamp wrong");
    a_reset_hold: assert property (
        (!por_n_i || !vme_local_reset_n_i)[*4]
        |-> !local_reset_n_o && !dram_reset_n_o)
        else $error("local reset not held");
    a_reset_release: assert property (
        quiet_q == QUIET |-> local_reset_n_o)
        else $error("local reset not released");
    a_sysreset_ctl: assert property (
        sysreset_oe_o |-> !local_reset_n_o && !dram_reset_n_o)
        else $error("backplane reset without local reset");
    a_dram_keep: assert property (
        (por_n_i && vme_local_reset_n_i && !vme_sysctl_i)[*5]
        |-> dram_reset_n_o && !sysreset_oe_o)
        else $error("memory reset while not controller");
    a_abort_cause: assert property (
        $fell(cpu0_nmi_n_o) |-> !$past(abort_btn_n_i, 3))
        else $error("abort interrupt without press");
    a_sysreset_drive: assert property (
        hold_q == HOLD |-> sysreset_oe_o && !dram_reset_n_o)
        else $error("backplane reset not driven");
endmodule // fpr_checker

bind fpr_top fpr_checker #(.DEB_CYCLES(DEB_CYCLES)) i_chk (
    .ref_clk_i, .arst_n_i, .reset_btn_n_i, .abort_btn_n_i, .por_n_i,
    .vme_local_reset_n_i, .local_reset_n_o, .dram_reset_n_o,
    .sysreset_oe_o, .cpu0_nmi_n_o, .vme_sysctl_i, .board_fail_line_i,
    .cpu_bus_activity_n_i, .lan_bus_master_i, .scsi_bus_master_i,
    .vme_master_i, .vme_slave_access_i, .fail_led_o, .sysctl_indicator_o,
    .run_led_o, .lan_led_o, .vme_led_o, .scsi_led_o);

`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        ref_clk_i = 1'h0;
    logic        arst_n_i  = 1'h0;
    logic [7:0]  addr      = 8'h00;
    logic [31:0] wdata     = 32'h0;
    logic [31:0] rdata;
    logic        wr = 1'h0, rd = 1'h0, irq, nmi_n;
    logic        rbtn_n = 1'h1, abtn_n = 1'h1, por_n = 1'h1, vrst_n = 1'h1;
    logic        lrst_n, drst_n, sr_o, sr_oe, sr_wire;
    logic        peer_n    = 1'h1;
    logic [6:0]  st = 7'h00;
    logic [5:0]  leds;
    int          num_errors = 0, checked = 0, cyc = 0;

    fpr_top #(.DEB_CYCLES(4)) i_dut (
        .ref_clk_i, .arst_n_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
        .reset_btn_n_i(rbtn_n), .abort_btn_n_i(abtn_n), .por_n_i(por_n),
        .vme_local_reset_n_i(vrst_n), .local_reset_n_o(lrst_n),
        .dram_reset_n_o(drst_n), .sysreset_n_i(sr_wire),
        .sysreset_n_o(sr_o), .sysreset_oe_o(sr_oe), .cpu0_nmi_n_o(nmi_n),
        .vme_sysctl_i(st[1]), .board_fail_line_i(st[0]),
        .cpu_bus_activity_n_i(~st[2]), .lan_bus_master_i(st[3]),
        .scsi_bus_master_i(st[6]), .vme_master_i(st[4]),
        .vme_slave_access_i(st[5]), .fail_led_o(leds[0]),
        .sysctl_indicator_o(leds[1]), .run_led_o(leds[2]),
        .lan_led_o(leds[3]), .vme_led_o(leds[4]), .scsi_led_o(leds[5]));

    fpr_backplane i_bp (.drive_en_i(sr_oe), .drive_lvl_i(sr_o),
        .peer_pull_n_i(peer_n), .line_n_o(sr_wire));

    always #10 ref_clk_i = ~ref_clk_i;

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // A hung run is cut short and reported as a failure.
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wt(int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge ref_clk_i);
        wr <= 1'h0;
    endtask

    task automatic rd_reg(logic [7:0] a, logic [31:0] e);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'h1;
        @(posedge ref_clk_i);
        rd <= 1'h0;
        @(posedge ref_clk_i);
        chk("rdata", e, rdata);
        @(posedge ref_clk_i);
        chk("rdata idle", 32'h0, rdata);
    endtask

    initial begin
        wt(10);
        arst_n_i <= 1'h1;
        wt(10);
        chk("local", 1, lrst_n);
        rd_reg(8'h00, 32'h1);
        rd_reg(8'h04, 32'h0);
        rd_reg(8'h08, 32'h0);
        rd_reg(8'h10, 32'h0);
        for (int i = 0; i < 8; i++) begin
            st <= (i < 7) ? 7'h01 << i : 7'h00;
            wt(6);
            chk("leds", {st[6], st[4] | st[5], st[3:0]}, leds);
        end
        chk("irq masked", 0, irq);
        por_n <= 1'h0;
        wt(6);
        chk("local", 2'h0, {lrst_n, drst_n});
        vrst_n <= 1'h0;
        por_n <= 1'h1;
        wt(6);
        chk("local", 2'h0, {lrst_n, drst_n});
        vrst_n <= 1'h1;
        st <= 7'h02;
        rbtn_n <= 1'h0;
        wt(12);
        chk("ctl", 4'h2, {lrst_n, drst_n, sr_oe, sr_wire});
        rd_reg(8'h04, 32'h6);
        rd_reg(8'h0C, 32'hB85);
        por_n <= 1'h0;
        rbtn_n <= 1'h1;
        wt(12);
        chk("ctl", 2'h0, {lrst_n, sr_oe});
        por_n <= 1'h1;
        st <= 7'h00;
        wt(12);
        chk("local", 2'h3, {lrst_n, drst_n});
        rbtn_n <= 1'h0;
        wt(12);
        chk("ctl", 3'h2, {lrst_n, drst_n, sr_oe});
        rbtn_n <= 1'h1;
        wr_reg(8'h04, 32'h7);
        wr_reg(8'h08, 32'h1);
        abtn_n <= 1'h0;
        wt(12);
        chk("nmi", 2'h1, {nmi_n, irq});
        abtn_n <= 1'h1;
        wt(12);
        chk("nmi", 1, nmi_n);
        wr_reg(8'h04, 32'h1);
        wt(3);
        chk("irq", 0, irq);
        wr_reg(8'h00, 32'h0);
        abtn_n <= 1'h0;
        wt(12);
        chk("nmi", 1, nmi_n);
        rd_reg(8'h04, 32'h1);
        abtn_n <= 1'h1;
        wt(12);
        peer_n <= 1'h0;
        wt(6);
        rd_reg(8'h0C, 32'h800);
        peer_n <= 1'h1;
        wt(3);
        print_verdict();
    end
endmodule // testbench

`default_nettype wire

// File: hw/fpr_sync.v
`timescale 1ns/1ps
`default_nettype none

module fpr_sync #(
    parameter integer WIDTH = 1,
    parameter [WIDTH-1:0] IDLE = {WIDTH{1'b0}}
) (
    input  wire             ref_clk_i,
    input  wire             arst_n_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            // The first stage feeds only the second stage.
            always @(posedge ref_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_q <= IDLE[g];
                    sync_q <= IDLE[g];
                end else begin
                    meta_q <= async_i[g];
                    sync_q <= meta_q;
                end
            end
            assign sync_o[g] = sync_q;
        end
    endgenerate

endmodule // fpr_sync

`default_nettype wire

// File: hw/fpr_top.v
// Overview of operation
// RULE1: Button as system controller resets all devices and drives SYSRESET.
// RULE2: Button as non-controller resets all except DRAM controller and corrector.
// RULE3: Local reset combines VMEbus unit reset, power-up reset and button.
// RULE4: Abort button raises the top-priority interrupt toward processor 0.
// RULE5: A software-writable abort enable bit gates that interrupt.
// RULE6: Fail indicator lit exactly while the board fail line is active.
// RULE7: Controller indicator lit while the VMEbus unit is system controller.
// RULE8: Run indicator lit while the processor bus activity line is low.
// RULE9: Network indicator lit while Ethernet controller masters peripheral bus.
// RULE10: VMEbus indicator lit while mastering or being accessed over VMEbus.
// RULE11: SCSI indicator lit while SCSI controller masters peripheral bus.
// RULE12: Local reset held while any source is active, released when all clear.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fpr_map.vh"

module fpr_top #(
    parameter integer DEB_CYCLES = `FPR_DEB_CYCLES,
    parameter integer DEB_W      = 20
) (
    input  wire        ref_clk_i,
    input  wire        arst_n_i,
    // Register port.
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output wire [31:0] reg_rdata_o,
    output wire        irq_o,
    // Operator buttons, pressed low.
    input  wire        reset_btn_n_i,
    input  wire        abort_btn_n_i,
    // Reset sources and targets.
    input  wire        por_n_i,
    input  wire        vme_local_reset_n_i,
    output wire        local_reset_n_o,
    output wire        dram_reset_n_o,
    // VMEbus SYSRESET open-drain line.
    input  wire        sysreset_n_i,
    output wire        sysreset_n_o,
    output wire        sysreset_oe_o,
    // Abort interrupt toward processor 0, active low.
    output wire        cpu0_nmi_n_o,
    // Board state for the indicators.
    input  wire        vme_sysctl_i,
    input  wire        board_fail_line_i,
    input  wire        cpu_bus_activity_n_i,
    input  wire        lan_bus_master_i,
    input  wire        scsi_bus_master_i,
    input  wire        vme_master_i,
    input  wire        vme_slave_access_i,
    // Indicators, high lights the lamp.
    output wire        fail_led_o,
    output wire        sysctl_indicator_o,
    output wire        run_led_o,
    output wire        lan_led_o,
    output wire        vme_led_o,
    output wire        scsi_led_o
);

    wire [`FPR_IN_W-1:0] raw_in;
    wire [`FPR_IN_W-1:0] syn;

    assign raw_in[`FPR_IN_RSTBTN_N] = reset_btn_n_i;
    assign raw_in[`FPR_IN_ABORT_N]  = abort_btn_n_i;
    assign raw_in[`FPR_IN_POR_N]    = por_n_i;
    assign raw_in[`FPR_IN_VLRST_N]  = vme_local_reset_n_i;
    assign raw_in[`FPR_IN_SYSCTL]   = vme_sysctl_i;
    assign raw_in[`FPR_IN_FAIL]     = board_fail_line_i;
    assign raw_in[`FPR_IN_CPUACT_N] = cpu_bus_activity_n_i;
    assign raw_in[`FPR_IN_LAN]      = lan_bus_master_i;
    assign raw_in[`FPR_IN_SCSI]     = scsi_bus_master_i;
    assign raw_in[`FPR_IN_VMEM]     = vme_master_i;
    assign raw_in[`FPR_IN_VMES]     = vme_slave_access_i;
    assign raw_in[`FPR_IN_SYSRST_N] = sysreset_n_i;

    fpr_sync #(
        .WIDTH (`FPR_IN_W),
        .IDLE  (`FPR_IN_IDLE)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .async_i   (raw_in),
        .sync_o    (syn)
    );

    // Button debounce. A press must hold steady for the whole debounce
    // time before it counts, so contact bounce cannot pulse the reset.
    // DEB_W must be wide enough for DEB_CYCLES - 1, or DEB_LAST is cut to DEB_W
    // bits, the counter matches early and the press counts too soon.
    localparam integer     DEB_LAST_I = DEB_CYCLES - 1;
    localparam [DEB_W-1:0] DEB_LAST   = DEB_LAST_I[DEB_W-1:0];

    wire [1:0] btn_raw;
    wire [1:0] btn_db;

    assign btn_raw[0] = ~syn[`FPR_IN_RSTBTN_N];
    assign btn_raw[1] = ~syn[`FPR_IN_ABORT_N];

    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1) begin : g_deb
            reg [DEB_W-1:0] cnt_q;
            reg             stable_q;
            always @(posedge ref_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    cnt_q    <= {DEB_W{1'b0}};
                    stable_q <= 1'b0;
                end else if (btn_raw[b] == stable_q) begin
                    cnt_q <= {DEB_W{1'b0}};
                end else if (cnt_q == DEB_LAST) begin
                    cnt_q    <= {DEB_W{1'b0}};
                    stable_q <= btn_raw[b];
                end else begin
                    cnt_q <= cnt_q + {{(DEB_W-1){1'b0}}, 1'b1};
                end
            end
            assign btn_db[b] = stable_q;
        end
    endgenerate

    wire rst_btn   = btn_db[0];
    wire abort_btn = btn_db[1];
    wire sysctl    = syn[`FPR_IN_SYSCTL];
    wire por_act   = ~syn[`FPR_IN_POR_N];
    wire vlrst_act = ~syn[`FPR_IN_VLRST_N];

    // Registers.
    reg [`FPR_CTRL_W-1:0] ctrl_q;
    reg [`FPR_EVT_W-1:0]  status_q;
    reg [`FPR_EVT_W-1:0]  status_d;
    reg [`FPR_EVT_W-1:0]  mask_q;
    reg [31:0]            rdata_q;
    reg [31:0]            rdata_d;
    reg                   irq_q;

    // Outputs and edge history.
    reg local_rst_n_q;
    reg dram_rst_n_q;
    reg sysrst_oe_q;
    reg sysrst_out_q;
    reg nmi_n_q;
    reg fail_q;
    reg sysctl_q;
    reg run_q;
    reg lan_q;
    reg vme_q;
    reg scsi_q;
    reg abort_prev_q;
    reg fail_prev_q;
    reg rstbtn_prev_q;

    wire abort_en = ctrl_q[`FPR_CTRL_ABORT_EN];
    wire wr_ctrl  = reg_wr_i && (reg_addr_i == `FPR_REG_CTRL);
    wire wr_stat  = reg_wr_i && (reg_addr_i == `FPR_REG_STATUS);
    wire wr_mask  = reg_wr_i && (reg_addr_i == `FPR_REG_MASK);

    wire [`FPR_EVT_W-1:0] evt;
    assign evt[`FPR_EVT_ABORT]  = abort_btn & ~abort_prev_q;
    assign evt[`FPR_EVT_FAIL]   = syn[`FPR_IN_FAIL] & ~fail_prev_q;
    assign evt[`FPR_EVT_RSTBTN] = rst_btn & ~rstbtn_prev_q;

    // A new event wins over a write-one clear in the same cycle.
    always @* begin
        status_d = status_q;
        if (wr_stat) begin
            status_d = status_q & ~reg_wdata_i[`FPR_EVT_W-1:0];
        end
        status_d = status_d | evt;
    end

    always @* begin
        rdata_d = 32'h00000000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `FPR_REG_CTRL: begin
                    rdata_d[`FPR_CTRL_W-1:0] = ctrl_q;
                end
                `FPR_REG_STATUS: begin
                    rdata_d[`FPR_EVT_W-1:0] = status_q;
                end
                `FPR_REG_MASK: begin
                    rdata_d[`FPR_EVT_W-1:0] = mask_q;
                end
                // State bits read one when active, whatever the pin sense.
                `FPR_REG_STATE: begin
                    rdata_d[11:0] = {~syn[`FPR_IN_SYSRST_N], abort_btn,
                                     rst_btn, ~dram_rst_n_q,
                                     ~local_rst_n_q, scsi_q, vme_q,
                                     lan_q, run_q, sysctl_q, fail_q,
                                     sysrst_oe_q};
                end
                default: begin
                    rdata_d = 32'h00000000;
                end
            endcase
        end
    end

    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q   <= `FPR_CTRL_RST;
            status_q <= `FPR_EVT_RST;
            mask_q   <= `FPR_EVT_RST;
            rdata_q  <= 32'h00000000;
            irq_q    <= 1'b0;
        end else begin
            // Abort enable control.
            // RULE5: software abort gate
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata_i[`FPR_CTRL_W-1:0];
            end
            if (wr_mask) begin
                mask_q <= reg_wdata_i[`FPR_EVT_W-1:0];
            end
            status_q <= status_d;
            rdata_q  <= rdata_d;
            irq_q    <= |(status_d & mask_q);
        end
    end

    // Reset generation. The local reset is held low during our own reset
    // so downstream logic never runs ahead of this controller.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            local_rst_n_q <= 1'b0;
            dram_rst_n_q  <= 1'b0;
            sysrst_oe_q   <= 1'b0;
            sysrst_out_q  <= 1'b0;
            rstbtn_prev_q <= 1'b0;
        end else begin
            rstbtn_prev_q <= rst_btn;
            // RULE3: three-source reset
            // RULE12: hold while any active
            local_rst_n_q <= ~(rst_btn | por_act | vlrst_act);
            // RULE2: DRAM spared off-controller
            dram_rst_n_q  <= ~((rst_btn & sysctl) | por_act | vlrst_act);
            // The backplane line is open drain: its level stays low and only
            // the enable moves, so we never drive it high against a peer.
            // RULE1: drive bus reset
            sysrst_oe_q   <= rst_btn & sysctl;
            sysrst_out_q  <= 1'b0;
        end
    end

    // Abort interrupt, held while the button is down and enabled.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            nmi_n_q      <= 1'b1;
            abort_prev_q <= 1'b0;
        end else begin
            abort_prev_q <= abort_btn;
            // RULE4: abort interrupt
            nmi_n_q      <= ~(abort_btn & abort_en);
        end
    end

    // Indicators.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fail_q      <= 1'b0;
            sysctl_q    <= 1'b0;
            run_q       <= 1'b0;
            lan_q       <= 1'b0;
            vme_q       <= 1'b0;
            scsi_q      <= 1'b0;
            fail_prev_q <= 1'b0;
        end else begin
            fail_prev_q <= syn[`FPR_IN_FAIL];
            // RULE6: fail lamp
            fail_q   <= syn[`FPR_IN_FAIL];
            // RULE7: controller lamp
            sysctl_q <= sysctl;
            // RULE8: run lamp
            run_q    <= ~syn[`FPR_IN_CPUACT_N];
            // RULE9: network lamp
            lan_q    <= syn[`FPR_IN_LAN];
            // RULE10: VMEbus lamp
            vme_q    <= syn[`FPR_IN_VMEM] | syn[`FPR_IN_VMES];
            // RULE11: SCSI lamp
            scsi_q   <= syn[`FPR_IN_SCSI];
        end
    end

    assign reg_rdata_o        = rdata_q;
    assign irq_o              = irq_q;
    assign local_reset_n_o    = local_rst_n_q;
    assign dram_reset_n_o     = dram_rst_n_q;
    assign sysreset_n_o       = sysrst_out_q;
    assign sysreset_oe_o      = sysrst_oe_q;
    assign cpu0_nmi_n_o       = nmi_n_q;
    assign fail_led_o         = fail_q;
    assign sysctl_indicator_o = sysctl_q;
    assign run_led_o          = run_q;
    assign lan_led_o          = lan_q;
    assign vme_led_o          = vme_q;
    assign scsi_led_o         = scsi_q;

endmodule // fpr_top

`default_nettype wire

// File: inc/fpr_map.vh
`ifndef FPR_MAP_VH
`define FPR_MAP_VH

// Clock rate and button debounce time.
`define FPR_CLK_MHZ        50
`define FPR_DEB_TIME_US    10000
`define FPR_DEB_CYCLES     (`FPR_DEB_TIME_US * `FPR_CLK_MHZ)

// Register offsets (byte addresses).
`define FPR_REG_CTRL       8'h00
`define FPR_REG_STATUS     8'h04
`define FPR_REG_MASK       8'h08
`define FPR_REG_STATE      8'h0C

// Control register fields and reset value.
`define FPR_CTRL_ABORT_EN  0
`define FPR_CTRL_W         1
`define FPR_CTRL_RST       1'h1

// Event bits shared by the status and mask registers.
`define FPR_EVT_ABORT      0
`define FPR_EVT_FAIL       1
`define FPR_EVT_RSTBTN     2
`define FPR_EVT_W          3
`define FPR_EVT_RST        3'h0

// Synchronised input vector layout.
`define FPR_IN_RSTBTN_N    0
`define FPR_IN_ABORT_N     1
`define FPR_IN_POR_N       2
`define FPR_IN_VLRST_N     3
`define FPR_IN_SYSCTL      4
`define FPR_IN_FAIL        5
`define FPR_IN_CPUACT_N    6
`define FPR_IN_LAN         7
`define FPR_IN_SCSI        8
`define FPR_IN_VMEM        9
`define FPR_IN_VMES        10
`define FPR_IN_SYSRST_N    11
`define FPR_IN_W           12
// Idle level of every input: active-low lines rest high.
`define FPR_IN_IDLE        12'h84F

`endif
